// *** design/dac_port_defs.vh ***
// Constants for the dual-DAC host write port.
// Assumes a 10 MHz system clock and a byte-wide or word-wide DAC bus.
`ifndef DAC_PORT_DEFS_VH
`define DAC_PORT_DEFS_VH
// Latch addresses on the byte-wide bus: {channel_select, byte_half_select}.
`define ADDR_A_LOW 2'h0
`define ADDR_A_HIGH 2'h1
`define ADDR_B_LOW 2'h2
`define ADDR_B_HIGH 2'h3
// Code limits for panning.
`define CODE_MIN 12'h001
`define CODE_MAX 12'hFFF
`define CODE_BALANCE 12'h800
`define CODE_FULL 13'h1_000
// Strobe timing: 200 ns low and 100 ns hold, in whole 100 ns clocks.
// The counts are sized to the sequencer's 3-bit counter so nothing is cut
// silently; revisit both together if the clock period ever changes.
`define STROBE_CYCLES 3'h2
`define HOLD_CYCLES 3'h1
`endif

// *** design/dac_host_port.v ***
// Host controller that loads a dual 12-bit DAC over its parallel pins.
// Assumes a single 10 MHz clock; the DAC is written on strobe edges only.
`include "dac_port_defs.vh"

// Summary of operation
// - Address bits 1:0 drive channel and byte-half selects on the byte bus.
// - Four byte-bus locations are used: two latches per channel; the load is its own strobe pin.
// - Byte mode sends right-justified 12-bit codes as two 8-bit writes.
// - The load strobe may also come from an outside timer or be shared.
// - Word mode gives each channel its own select and loads 12 bits at once.
// - The acknowledge is the AND of the two active-low channel selects.
// - Panning writes the second channel the two's complement of the first.
// - Code 2048 on both channels is the balanced position.
// - A load never overlaps a write; an outside load starts only from idle.
module dac_host_port (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // User request side.
  input wire reqValid,
  input wire [1:0] reqKind,
  input wire [11:0] reqCodeA,
  input wire [11:0] reqCodeB,
  input wire wordMode,
  input wire extLoadRequest,
  output reg reqReady,
  // DAC pins.
  output reg [11:0] dataBus,
  output reg [1:0] addrBus,
  output reg dacSelect_n,
  output reg channel_a_select_n,
  output reg channel_b_select_n,
  output reg write_n,
  output reg load_outputs_strobe_n,
  output reg transfer_acknowledge_n
);

  // Request kinds: write A, write B, write both, pan (A given, B derived).
  localparam [1:0] KIND_A = 2'h0;
  localparam [1:0] KIND_B = 2'h1;
  localparam [1:0] KIND_BOTH = 2'h2;
  localparam [1:0] KIND_PAN = 2'h3;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_STROBE = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_LOAD = 3'h4;
  localparam [2:0] ST_EXTLOAD = 3'h5;

  localparam [2:0] STROBE_N = `STROBE_CYCLES;
  localparam [2:0] HOLD_N = `HOLD_CYCLES;

  reg [2:0] state;
  reg [2:0] count;
  reg [2:0] step;
  reg [2:0] lastStep;
  reg [11:0] codeA;
  reg [11:0] codeB;
  reg modeWord;
  reg extSync1;
  reg extSync2;
  reg extSeen;
  reg [11:0] panA;
  reg [11:0] stepData;
  reg [1:0] stepAddr;
  reg stepIsLoad;
  reg stepSelA;
  reg stepSelB;

  // The outside load request is a pin, so it is synchronised first.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
    end else begin
      extSync1 <= extLoadRequest;
      extSync2 <= extSync1;
    end
  end

  // Clamp the pan code so neither channel ever sees zero.
  always @* begin
    panA = reqCodeA;
    if (reqCodeA < `CODE_MIN) begin
      panA = `CODE_MIN;
    end
  end

  // Decode the current step into pins. Byte mode walks A low, A high,
  // B low, B high, then the load strobe; word mode uses one write each.
  always @* begin
    stepData = 12'h000;
    stepAddr = `ADDR_A_LOW;
    stepIsLoad = 1'b0;
    stepSelA = 1'b0;
    stepSelB = 1'b0;
    if (modeWord) begin
      // One write carries the whole word per channel.
      stepSelA = (step == 3'h0);
      stepSelB = (step == 3'h1);
      stepData = (step == 3'h0) ? codeA : codeB;
    end else begin
      case (step)
        3'h0: begin
          stepAddr = `ADDR_A_LOW;
          stepData = {4'h0, codeA[7:0]};
        end
        3'h1: begin
          stepAddr = `ADDR_A_HIGH;
          stepData = {8'h00, codeA[11:8]};
        end
        3'h2: begin
          stepAddr = `ADDR_B_LOW;
          stepData = {4'h0, codeB[7:0]};
        end
        3'h3: begin
          stepAddr = `ADDR_B_HIGH;
          stepData = {8'h00, codeB[11:8]};
        end
        default: begin
          stepIsLoad = 1'b1;
        end
      endcase
    end
  end

  // Main sequencer. Every pin is a flop, so timing edges are clean.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      count <= 3'h0;
      step <= 3'h0;
      lastStep <= 3'h0;
      codeA <= `CODE_BALANCE;
      codeB <= `CODE_BALANCE;
      modeWord <= 1'b0;
      extSeen <= 1'b0;
      reqReady <= 1'b0;
      dataBus <= 12'h000;
      addrBus <= 2'h0;
      dacSelect_n <= 1'b1;
      channel_a_select_n <= 1'b1;
      channel_b_select_n <= 1'b1;
      write_n <= 1'b1;
      load_outputs_strobe_n <= 1'b1;
      transfer_acknowledge_n <= 1'b1;
    end else begin
      extSeen <= extSync2;
      // Acknowledge is low when either channel select is low.
      transfer_acknowledge_n <= channel_a_select_n & channel_b_select_n;
      case (state)
        ST_IDLE: begin
          reqReady <= 1'b1;
          if (extSync2 && !extSeen) begin
            // Outside load runs only between writes, so it never overlaps.
            reqReady <= 1'b0;
            load_outputs_strobe_n <= 1'b0;
            count <= 3'h0;
            state <= ST_EXTLOAD;
          end else if (reqValid) begin
            reqReady <= 1'b0;
            modeWord <= wordMode;
            codeA <= reqCodeA;
            codeB <= reqCodeB;
            step <= (reqKind == KIND_B) ? (wordMode ? 3'h1 : 3'h2) : 3'h0;
            if (wordMode) begin
              lastStep <= (reqKind == KIND_A) ? 3'h0 : 3'h1;
            end else begin
              lastStep <= 3'h4;
            end
            if (reqKind == KIND_PAN) begin
              codeA <= panA;
              // Two's complement keeps the pair summing to 4096.
              codeB <= (~panA) + 12'h001;
            end
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Address and data settle a cycle before the strobe falls.
          dataBus <= stepData;
          addrBus <= stepAddr;
          count <= 3'h0;
          state <= ST_STROBE;
        end
        ST_STROBE: begin
          if (stepIsLoad) begin
            load_outputs_strobe_n <= 1'b0;
          end else begin
            write_n <= 1'b0;
            dacSelect_n <= modeWord;
            channel_a_select_n <= ~stepSelA;
            channel_b_select_n <= ~stepSelB;
          end
          count <= count + 3'h1;
          if (count == STROBE_N - 3'h1) begin
            count <= 3'h0;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Rising write edge latches the word; data held one more period.
          write_n <= 1'b1;
          dacSelect_n <= 1'b1;
          channel_a_select_n <= 1'b1;
          channel_b_select_n <= 1'b1;
          load_outputs_strobe_n <= 1'b1;
          count <= count + 3'h1;
          if (count == HOLD_N - 3'h1) begin
            count <= 3'h0;
            if (step == lastStep) begin
              state <= ST_IDLE;
            end else begin
              // Skip channel B writes when only A was asked for.
              if (!modeWord && reqKindA(step)) begin
                step <= 3'h4;
              end else begin
                step <= step + 3'h1;
              end
              state <= ST_SETUP;
            end
          end
        end
        ST_EXTLOAD: begin
          count <= count + 3'h1;
          if (count == STROBE_N - 3'h1) begin
            load_outputs_strobe_n <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Remember whether a byte-mode request covered channel A only.
  reg onlyA;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      onlyA <= 1'b0;
    end else if (state == ST_IDLE && reqValid) begin
      onlyA <= (reqKind == KIND_A);
    end
  end

  function reqKindA;
    input [2:0] s;
    begin
      reqKindA = onlyA && (s == 3'h1);
    end
  endfunction

endmodule // dac_host_port

// *** test/dac_port_checker_asserts.sv ***
// Pin timing checker for the dual DAC host port.
// Assumes it is bound to dac_host_port and sees only its ports.
module dac_port_checker (
  // Clock, reset and request.
  input logic sys_clk,
  input logic rst_n,
  input logic reqValid,
  input logic reqReady,
  input logic wordMode,
  // DAC pins.
  input logic [1:0] addrBus,
  input logic dacSelect_n,
  input logic channel_a_select_n,
  input logic channel_b_select_n,
  input logic write_n,
  input logic load_outputs_strobe_n,
  input logic transfer_acknowledge_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // A strobe pulse is exactly two cycles low, then back high.
  sequence twoLow(s);
    !s ##1 !s ##1 s;
  endsequence
  chk_write_two: assert property ($fell(write_n) |-> twoLow(write_n))
    else $error("write strobe width wrong");
  chk_load_two: assert property ($fell(load_outputs_strobe_n) |->
    twoLow(load_outputs_strobe_n))
    else $error("load strobe width wrong");
  chk_ack_and: assert property (transfer_acknowledge_n ==
    $past(channel_a_select_n & channel_b_select_n))
    else $error("acknowledge is not the select AND");
  chk_byte_sel: assert property (!wordMode && !write_n |-> !dacSelect_n
    && channel_a_select_n && channel_b_select_n)
    else $error("byte write without byte select");
  chk_word_sel: assert property (wordMode && !write_n |-> dacSelect_n
    && !(channel_a_select_n && channel_b_select_n))
    else $error("word write without channel select");
  chk_addr_hold: assert property (!write_n |-> $stable(addrBus))
    else $error("address moved during write");
  chk_no_overlap: assert property (!load_outputs_strobe_n |-> write_n)
    else $error("load overlaps a write");
  chk_take_busy: assert property (reqValid && reqReady |=> !reqReady)
    else $error("request not taken");
endmodule // dac_port_checker
bind dac_host_port dac_port_checker chk (.sys_clk, .rst_n, .reqValid,
  .reqReady, .wordMode, .addrBus, .dacSelect_n, .channel_a_select_n,
  .channel_b_select_n, .write_n, .load_outputs_strobe_n,
  .transfer_acknowledge_n);

// *** test/dac_model.sv ***
// Behavioural model of the dual DAC as seen at its digital pins.
// Assumes the host holds data and address across every strobe edge.
module dac_model (
  // Host pins.
  input logic [11:0] dataBus,
  input logic [1:0] addrBus,
  input logic dacSelect_n,
  input logic channel_a_select_n,
  input logic channel_b_select_n,
  input logic write_n,
  input logic load_outputs_strobe_n,
  // Output latch contents.
  output logic [11:0] outA,
  output logic [11:0] outB
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] loA, loB;
  logic [3:0] hiA, hiB;
  logic wrA, wrB;
  // Only the addressed input latch is transparent; the rest keep contents.
  always @* begin
    if (!dacSelect_n && !write_n) begin
      case (addrBus)
        2'h0: loA = dataBus[7:0];
        2'h1: hiA = dataBus[3:0];
        2'h2: loB = dataBus[7:0];
        default: hiB = dataBus[3:0];
      endcase
    end
  end
  // Output latches follow the input latches while the load is low.
  always @* begin
    if (!load_outputs_strobe_n) begin
      outA = {hiA, loA};
      outB = {hiB, loB};
    end
  end
  // Selects are remembered during the pulse, since they rise with write.
  always @* begin
    if (!write_n) begin
      wrA = !channel_a_select_n;
      wrB = !channel_b_select_n;
    end
  end
  always @(posedge write_n) begin
    if (wrA) outA = dataBus;
    if (wrB) outB = dataBus;
  end
endmodule // dac_model

// *** test/dac_host_port_test.sv ***
// Self-checking bench for the DAC host port driving a DAC pin model.
// Assumes the design, model and checker files are compiled first.
module dac_host_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, reqValid, wordMode, extLoadRequest, reqReady;
  logic [1:0] reqKind, addrBus;
  logic [11:0] reqCodeA, reqCodeB, dataBus, outA, outB;
  logic dacSelect_n, channel_a_select_n, channel_b_select_n;
  logic write_n, load_outputs_strobe_n, transfer_acknowledge_n;
  int err_count = 0;
  int num_checks = 0;
  int ackLow = 0;
  // Count cycles of acknowledge low, as the host glue would see them.
  always @(posedge sys_clk) begin
    if (!transfer_acknowledge_n) ackLow <= ackLow + 1;
  end
  dac_host_port DUT (.sys_clk, .rst_n, .reqValid, .reqKind, .reqCodeA,
    .reqCodeB, .wordMode, .extLoadRequest, .reqReady, .dataBus, .addrBus,
    .dacSelect_n, .channel_a_select_n, .channel_b_select_n, .write_n,
    .load_outputs_strobe_n, .transfer_acknowledge_n);
  dac_model pins (.dataBus, .addrBus, .dacSelect_n, .channel_a_select_n,
    .channel_b_select_n, .write_n, .load_outputs_strobe_n, .outA, .outB);
  task automatic end_of_test;
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One request; the wait is bounded so a stuck port cannot hang here.
  task automatic req(input logic [1:0] k, input logic [11:0] a, b);
    reqKind = k;
    reqCodeA = a;
    reqCodeB = b;
    reqValid = 1'b1;
    @(posedge sys_clk);
    #10 reqValid = 1'b0;
    repeat (80) if (reqReady !== 1'b1) @(posedge sys_clk) #10;
    // A port that never comes back counts as a mismatch.
    if (reqReady !== 1'b1) err_count++;
  endtask
  // Byte bus: both channels, then A alone leaves B untouched.
  task automatic t_byte;
    wordMode = 1'b0;
    req(2'h2, 12'h05A3, 12'h0C3E);
    chk(outA, 12'h05A3);
    chk(outB, 12'h0C3E);
    req(2'h0, 12'h00FF, 12'h0777);
    chk(outA, 12'h00FF);
    chk(outB, 12'h0C3E);
    req(2'h1, 12'h0000, 12'h0246);
    chk(outA, 12'h00FF);
    chk(outB, 12'h0246);
  endtask
  // Panning, with the zero code and the balanced code.
  task automatic t_pan;
    req(2'h3, 12'h0000, 12'h0000);
    chk(outA, 12'h0001);
    chk(outB, 12'h0FFF);
    req(2'h3, 12'h0800, 12'h0000);
    chk(outA, 12'h0800);
    chk(outB, 12'h0800);
  endtask
  // Word bus: full codes in one write per channel.
  task automatic t_word;
    int base;
    wordMode = 1'b1;
    base = ackLow;
    req(2'h2, 12'h0123, 12'h0ABC);
    chk(outA, 12'h0123);
    chk(outB, 12'h0ABC);
    chk(12'(ackLow - base), 12'h004);
    req(2'h1, 12'h0000, 12'h0456);
    chk(outA, 12'h0123);
    chk(outB, 12'h0456);
    req(2'h0, 12'h0789, 12'h0000);
    chk(outA, 12'h0789);
    chk(outB, 12'h0456);
    chk(12'(ackLow - base), 12'h008);
  endtask
  // An outside load pulse copies the held input latches to the outputs.
  task automatic t_ext;
    wordMode = 1'b0;
    extLoadRequest = 1'b1;
    repeat (10) @(posedge sys_clk);
    #10 extLoadRequest = 1'b0;
    chk(outA, 12'h0800);
    chk(outB, 12'h0800);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // A full run needs about 13.4 us; this limit leaves ample margin.
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    reqKind = 2'h0;
    reqCodeA = 12'h0000;
    reqCodeB = 12'h0000;
    wordMode = 1'b0;
    extLoadRequest = 1'b0;
    repeat (6) @(posedge sys_clk);
    #10 rst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    #10;
    t_byte();
    t_pan();
    t_word();
    t_ext();
    end_of_test();
  end
endmodule // dac_host_port_test
